/* File: core/sdd_top.sv */
// Purpose: master clock division, ratio decode, decimation timing and three channel filters
// Assumes: master clock is an asynchronous pin well below half the system clock rate
// Notes: ratio config is taken at each output sample boundary and once after reset; power mode follows every enabled cycle
// Functional notes
// RQ1: host keeps master clock running during conversions
// RQ2: two-bit power mode picks one of three
// RQ3: host matches master clock to power mode
// RQ4: modulator runs at half the master clock
// RQ5: one output per ratio modulator periods
// RQ6: three-bit ratio field, turbo picks 64
// RQ7: nine ratios, powers of two 64..16384
// RQ8: linear-phase sinc averaging of modulator bits
// RQ9: first two outputs sinc1, then sinc3 path
// RQ10: ratios 2048 up: sinc3 at 1024, sinc1 rest
// RQ11: field 0..7 maps 128..16384; turbo gives 64
`timescale 1ns/10ps
module sdd_top
  import sdd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_master_clock_input,
  input wire logic [N_CH-1:0] i_mod_bits,
  input wire logic [1:0] i_power_mode_select,
  input wire logic [2:0] i_oversampling_ratio_select,
  input wire logic i_turbo_ratio_enable,
  output logic [N_CH-1:0][DATA_W-1:0] o_ch_data,
  output logic o_sample_valid,
  output logic o_fast_settle,
  output logic o_modulator_strobe,
  output logic o_high_resolution_mode,
  output logic o_low_power_mode,
  output logic o_very_low_power_mode,
  output logic [3:0] o_osr_log2
);
  logic [1:0] rst_sq;  // reset release synchroniser
  wire logic rst_n;
  logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q;  // pin synchroniser stages
  logic [SYNC_W-1:0] lvl_q;  // accepted pin levels
  logic phase_q;  // master clock divider phase
  logic [CNT_W-1:0] cnt_q;  // modulator periods within the frame
  logic started_q;  // first config load done
  logic [3:0] kf_q, k3_q, kr_q;  // latched ratio exponents
  logic [1:0] conv_q;  // conversions since reset, saturating
  logic [1:0] rise_cnt_q;  // master rises since last modulator strobe
  logic [CNT_W:0] stb_cnt_q;  // modulator strobes since last output
  logic [1:0] valid_cnt_q;  // output pulses since reset, saturating
  wire logic [SYNC_W-1:0] agree;
  wire logic [SYNC_W-1:0] lvl_d;
  wire logic rise;
  wire logic mod_stb;
  wire logic dec3_stb;
  wire logic out_stb;
  wire logic load_cfg;
  wire logic sel_fast;
  wire logic [3:0] kf_new;
  wire logic [3:0] k3_new;
  wire logic [CNT_W-1:0] m3;
  wire logic [CNT_W-1:0] mf;
  sdd_pwr_e pwr_d;
  sdd_ctl_if ctl ();

  // reset released through two flops
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rst_sq <= 2'h0;
    else
      rst_sq <= {rst_sq[0], 1'b1};
  end
  assign rst_n = rst_sq[1];

  // pin levels accepted once stages two and three agree
  assign agree = ~(sync2_q ^ sync3_q);
  assign lvl_d = (lvl_q & ~agree) | (sync3_q & agree);
  assign rise = i_clk_en && lvl_d[N_CH] && !lvl_q[N_CH];
  // every second master rise is one modulator period
  assign mod_stb = rise && phase_q;  // see RQ4
  // frame timing from the low bits of the period counter
  assign m3 = sdd_low_mask(k3_q);
  assign mf = sdd_low_mask(kf_q);
  assign dec3_stb = mod_stb && ((cnt_q & m3) == m3);  // see RQ10
  assign out_stb = mod_stb && ((cnt_q & mf) == mf);  // see RQ5
  assign load_cfg = i_clk_en && (out_stb || !started_q);
  assign sel_fast = conv_q < FAST_CONVS;  // see RQ9
  // ratio decode and split between the two stages
  assign kf_new = sdd_osr_log(i_oversampling_ratio_select, i_turbo_ratio_enable);  // see RQ11
  assign k3_new = (kf_new > SINC3_MAX_LOG) ? SINC3_MAX_LOG : kf_new;  // see RQ10
  // power mode decode
  assign pwr_d = (i_power_mode_select == PWR_VLP_CODE) ? SDD_VLP :
                 (i_power_mode_select == PWR_LP_CODE) ? SDD_LP : SDD_HR;  // see RQ2
  // control carried to the channels
  assign ctl.mod_stb = mod_stb;
  assign ctl.dec3_stb = dec3_stb;
  assign ctl.out_stb = out_stb;
  assign ctl.sel_fast = sel_fast;
  assign ctl.k3 = k3_q;
  assign ctl.kr = kr_q;
  assign ctl.kf = kf_q;

  // synchroniser stages and accepted levels
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      lvl_q <= '0;
    end
    else if (i_clk_en)
    begin
      sync1_q <= {i_master_clock_input, i_mod_bits};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q <= lvl_d;
    end
  end

  // divider phase and period counter
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      if (rise)
        phase_q <= ~phase_q;  // see RQ4
      if (mod_stb)
        cnt_q <= out_stb ? '0 : cnt_q + CNT_W'(1);
    end
  end

  // ratio config taken at frame boundaries and once after reset
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      started_q <= 1'b0;
      kf_q <= OSR_RST_LOG;
      k3_q <= OSR_RST_LOG;
      kr_q <= 4'h0;
    end
    else if (load_cfg)
    begin
      started_q <= 1'b1;
      kf_q <= kf_new;  // see RQ6, RQ7
      k3_q <= k3_new;
      kr_q <= kf_new - k3_new;  // see RQ10
    end
  end

  // conversion count, sample pulse and status outputs
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_q <= 2'h0;
      o_sample_valid <= 1'b0;
      o_fast_settle <= 1'b1;
      o_modulator_strobe <= 1'b0;
      o_high_resolution_mode <= 1'b1;
      o_low_power_mode <= 1'b0;
      o_very_low_power_mode <= 1'b0;
      o_osr_log2 <= OSR_RST_LOG;
    end
    else if (i_clk_en)
    begin
      if (out_stb && sel_fast)
        conv_q <= conv_q + 2'h1;  // see RQ9
      o_sample_valid <= out_stb;
      if (out_stb)
        o_fast_settle <= sel_fast;
      o_modulator_strobe <= mod_stb;
      o_high_resolution_mode <= (pwr_d == SDD_HR);
      o_low_power_mode <= (pwr_d == SDD_LP);
      o_very_low_power_mode <= (pwr_d == SDD_VLP);
      o_osr_log2 <= kf_q;
    end
  end

  // one filter per channel
  for (genvar g = 0; g < N_CH; g++)
  begin : g_chan
    sdd_chan u_chan (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_clk_en(i_clk_en),
      .i_bit(lvl_q[g]),
      .ctl(ctl.chan),
      .o_data(o_ch_data[g])
    );
  end

  // helper counters watched by the checks below
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_cnt_q <= 2'h0;
      stb_cnt_q <= '0;
      valid_cnt_q <= 2'h0;
    end
    else
    begin
      if (mod_stb)
        rise_cnt_q <= 2'h0;
      else if (rise && rise_cnt_q != 2'h3)
        rise_cnt_q <= rise_cnt_q + 2'h1;
      if (out_stb)
        stb_cnt_q <= '0;
      else if (mod_stb)
        stb_cnt_q <= stb_cnt_q + (CNT_W+1)'(1);
      if (i_clk_en && o_sample_valid && valid_cnt_q != 2'h3)
        valid_cnt_q <= valid_cnt_q + 2'h1;
    end
  end

  a_mod_half_rate: assert property (@(posedge i_clk) disable iff (!rst_n) // see RQ4
    mod_stb |-> (rise && rise_cnt_q == 2'h1))
    else $error("modulator strobe not on every second master rise");
  a_out_every_osr: assert property (@(posedge i_clk) disable iff (!rst_n) // see RQ5
    out_stb |-> (stb_cnt_q + (CNT_W+1)'(1)) == ((CNT_W+1)'(1) << kf_q))
    else $error("output spacing differs from the ratio");
  a_valid_follows: assert property (@(posedge i_clk) disable iff (!rst_n) // see RQ5
    (i_clk_en && out_stb) |=> (o_sample_valid && o_fast_settle == $past(sel_fast)))
    else $error("sample pulse missing after output point");
  // sampled reset keeps the release edge out: the flops were still held there
  a_turbo_ratio: assert property (@(posedge i_clk) disable iff (!rst_n) // see RQ6
    (rst_n && load_cfg && i_turbo_ratio_enable) |=> kf_q == OSR_MIN_LOG)
    else $error("turbo did not select ratio 64");
  a_ratio_map: assert property (@(posedge i_clk) disable iff (!rst_n) // see RQ11
    (rst_n && load_cfg && !i_turbo_ratio_enable) |=>
      kf_q == OSR_FIELD_BASE + {1'b0, $past(i_oversampling_ratio_select)})
    else $error("ratio field mapped wrongly");
  a_ratio_range: assert property (@(posedge i_clk) disable iff (!rst_n) // see RQ7
    kf_q >= OSR_MIN_LOG && kf_q <= OSR_MAX_LOG)
    else $error("ratio outside 64 to 16384");
  a_sinc3_split: assert property (@(posedge i_clk) disable iff (!rst_n) // see RQ10
    ##1 (k3_q == ((kf_q > SINC3_MAX_LOG) ? SINC3_MAX_LOG : kf_q)) && (k3_q + kr_q == kf_q))
    else $error("sinc3 and sinc1 ratio split wrong");
  a_fast_two: assert property (@(posedge i_clk) disable iff (!rst_n) // see RQ9
    o_sample_valid |-> o_fast_settle == (valid_cnt_q < FAST_CONVS))
    else $error("fast path not used for exactly two outputs");
  a_power_onehot: assert property (@(posedge i_clk) disable iff (!rst_n) // see RQ2
    ##1 $onehot({o_high_resolution_mode, o_low_power_mode, o_very_low_power_mode}))
    else $error("power mode outputs not one-hot");
endmodule

/* File: core/sdd_pkg.sv */
// Purpose: shared constants, types and decode helpers for the decimation clocking path
// Assumes: one system clock; config bits come from logic on that clock
// Notes: ratios are kept as base-two exponents throughout
package sdd_pkg;
  // channel count and data widths
  localparam int N_CH = 3;
  localparam int DATA_W = 24;
  localparam int CIC_W = 31;
  localparam int ACC_W = 35;
  localparam int FAST_W = 15;
  localparam int CNT_W = 14;
  localparam int SYNC_W = N_CH + 1;
  // ratio exponents: 64, 16384, field base 128, sinc3 ceiling 1024
  localparam logic [3:0] OSR_MIN_LOG = 4'h6;
  localparam logic [3:0] OSR_MAX_LOG = 4'he;
  localparam logic [3:0] OSR_FIELD_BASE = 4'h7;
  localparam logic [3:0] SINC3_MAX_LOG = 4'ha;
  // ratio exponent held after reset until the first config load
  localparam logic [3:0] OSR_RST_LOG = 4'h7;
  // exponent of the common full-scale level before truncation
  localparam logic [5:0] NORM_EXP = 6'h22;
  // number of fast-settling conversions after reset
  localparam logic [1:0] FAST_CONVS = 2'h2;
  // master clock rises per modulator period
  localparam int MOD_DIV = 2;
  // power mode field codes; any other code means high resolution
  localparam logic [1:0] PWR_VLP_CODE = 2'h0;
  localparam logic [1:0] PWR_LP_CODE = 2'h1;
  // power modes
  typedef enum logic [1:0] {SDD_HR, SDD_LP, SDD_VLP} sdd_pwr_e;
  // ratio exponent from the select field and turbo bit
  function automatic logic [3:0] sdd_osr_log(input logic [2:0] sel, input logic turbo);
    sdd_osr_log = turbo ? OSR_MIN_LOG : OSR_FIELD_BASE + {1'b0, sel};
  endfunction
  // mask of the low k bits of the frame counter
  function automatic logic [CNT_W-1:0] sdd_low_mask(input logic [3:0] k);
    sdd_low_mask = (CNT_W'(1) << k) - CNT_W'(1);
  endfunction
endpackage

/* File: core/sdd_ctl_if.sv */
// Purpose: control strobes and ratio exponents from the timing core to each channel
// Assumes: all signals on the system clock
// Notes: strobes are one cycle wide and already qualified by the clock enable
`timescale 1ns/10ps
interface sdd_ctl_if;
  logic mod_stb;  // one modulator period elapsed
  logic dec3_stb;  // sinc3 decimation point
  logic out_stb;  // output sample point
  logic sel_fast;  // this output comes from the fast-settling path
  logic [3:0] k3;  // sinc3 ratio exponent
  logic [3:0] kr;  // sinc1 ratio exponent
  logic [3:0] kf;  // overall ratio exponent
  modport ctl (output mod_stb, dec3_stb, out_stb, sel_fast, k3, kr, kf);
  modport chan (input mod_stb, dec3_stb, out_stb, sel_fast, k3, kr, kf);
endinterface

/* File: core/sdd_chan.sv */
// Purpose: one channel of sinc3 plus sinc1 decimation, with a parallel sinc1 fast path
// Assumes: modulator bit already synchronised and sampled on ctl.mod_stb
// Notes: output is the ones density, full scale 0x800000
`timescale 1ns/10ps
module sdd_chan
  import sdd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_bit,
  sdd_ctl_if.chan ctl,
  output logic [DATA_W-1:0] o_data
);
  logic [CIC_W-1:0] int1_q, int2_q, int3_q;  // integrator chain
  logic [CIC_W-1:0] dly1_q, dly2_q, dly3_q;  // comb delays
  logic [ACC_W-1:0] s1_q;  // sinc1 accumulator of sinc3 outputs
  logic [FAST_W-1:0] fast_q;  // fast path ones count
  wire logic [CIC_W-1:0] int1_d;
  wire logic [CIC_W-1:0] int2_d;
  wire logic [CIC_W-1:0] int3_d;
  wire logic [CIC_W-1:0] diff1;
  wire logic [CIC_W-1:0] diff2;
  wire logic [CIC_W-1:0] diff3;
  wire logic [ACC_W-1:0] s1_sum;
  wire logic [FAST_W-1:0] fast_d;
  wire logic [5:0] e3;
  wire logic [ACC_W-1:0] norm3;
  wire logic [ACC_W-1:0] normf;
  wire logic [ACC_W-1:0] pick;

  // integrators include the current bit; wrap-around is harmless for the combs
  assign int1_d = int1_q + CIC_W'(i_bit);  // see RQ8
  assign int2_d = int2_q + int1_d;
  assign int3_d = int3_q + int2_d;
  // three combs at the decimated rate
  assign diff1 = int3_d - dly1_q;  // see RQ8
  assign diff2 = diff1 - dly2_q;
  assign diff3 = diff2 - dly3_q;
  // second stage adds up 1 to 16 sinc3 results
  assign s1_sum = s1_q + ACC_W'(diff3);  // see RQ10
  assign fast_d = fast_q + FAST_W'(i_bit);  // see RQ9
  // scale both paths to the same full scale
  assign e3 = 6'({ctl.k3, 1'b0}) + 6'(ctl.k3) + 6'(ctl.kr);
  assign norm3 = s1_sum << (NORM_EXP - e3);
  assign normf = ACC_W'(fast_d) << (NORM_EXP - {2'h0, ctl.kf});
  assign pick = ctl.sel_fast ? normf : norm3;  // see RQ9

  // filter state advances once per modulator period
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      int1_q <= '0;
      int2_q <= '0;
      int3_q <= '0;
      dly1_q <= '0;
      dly2_q <= '0;
      dly3_q <= '0;
      s1_q <= '0;
      fast_q <= '0;
      o_data <= '0;
    end
    else if (i_clk_en && ctl.mod_stb)
    begin
      int1_q <= int1_d;
      int2_q <= int2_d;
      int3_q <= int3_d;
      fast_q <= ctl.out_stb ? '0 : fast_d;  // see RQ5
      if (ctl.dec3_stb)
      begin
        dly1_q <= int3_d;
        dly2_q <= diff1;
        dly3_q <= diff2;
        s1_q <= ctl.out_stb ? '0 : s1_sum;
      end
      if (ctl.out_stb)
      begin
        o_data <= pick[ACC_W-1 -: DATA_W];  // see RQ5
      end
    end
  end

  // a fast-path average can never exceed full scale
  a_fast_full_scale: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RQ8
    (i_clk_en && ctl.mod_stb && ctl.out_stb && ctl.sel_fast) |=> o_data <= 24'h800000)
    else $error("fast path output above full scale");
endmodule

/* File: tb/sdd_src_model.sv */
// Purpose: master clock source and modulator bit streams for the top
// Assumes: stepped from the bench clock, free running from time zero
// Notes: ch0 all ones, ch1 all zeros, ch2 half density
`timescale 1ns/10ps
module sdd_src_model #(
  parameter int HALF = 3  // system clocks per master half period
)(
  input wire logic i_clk,
  output logic o_mclk,
  output logic [2:0] o_bits
);
  int cnt = 0;  // cycles into the half period
  logic [1:0] per = 2'h0;  // master periods seen
  initial
  begin
    o_mclk = 1'b0;
    o_bits = 3'b001;
  end
  // clock never pauses; one scaled rate for every mode, the nominal
  // rates being beyond what the synchroniser can follow
  always @(posedge i_clk)
  begin
    if (cnt == HALF - 1)
    begin
      cnt <= 0;
      o_mclk <= ~o_mclk;
      // bits move on the falling edge, well away from the sampling rise
      if (o_mclk)
      begin
        per <= per + 2'h1;
        o_bits[2] <= per[1];
      end
    end
    else
      cnt <= cnt + 1;
  end
endmodule

/* File: tb/sdd_tb_top.sv */
// Purpose: self-checking bench for the decimation clocking top
// Assumes: master clock at one sixth of the system rate
// Notes: long ratios are checked by decode only, save 2048 with one sample, to keep the run short
`timescale 1ns/10ps
module sdd_tb_top;
  import sdd_pkg::*;
  // one table row: config in, decode and sample count expected
  typedef struct {logic [1:0] pwr; logic [2:0] sel; logic turbo;
    logic [3:0] k; logic [2:0] hot; int n;} sdd_row_s;
  logic clk, nrst, clk_en, mclk, turbo, valid, fast, mstb, hr, lp, very_low_power_mode;
  logic [2:0] bits;
  logic [2:0] sel;
  logic [1:0] pwr;
  logic [3:0] osr;
  logic [N_CH-1:0][DATA_W-1:0] data;
  int errors = 0;
  int n_checks = 0;
  int ns;  // periods or cycles counted by the wait tasks
  sdd_row_s rows[10] = '{
    '{2'h0, 3'h0, 1'b1, 4'h6, 3'h1, 4}, '{2'h1, 3'h0, 1'b0, 4'h7, 3'h2, 4},
    '{2'h2, 3'h1, 1'b0, 4'h8, 3'h4, 4}, '{2'h3, 3'h2, 1'b0, 4'h9, 3'h4, 0},
    '{2'h0, 3'h3, 1'b0, 4'ha, 3'h1, 0}, '{2'h1, 3'h4, 1'b0, 4'hb, 3'h2, 1},
    '{2'h2, 3'h5, 1'b0, 4'hc, 3'h4, 0}, '{2'h3, 3'h6, 1'b0, 4'hd, 3'h4, 0},
    '{2'h0, 3'h7, 1'b1, 4'h6, 3'h1, 0}, '{2'h1, 3'h7, 1'b0, 4'he, 3'h2, 0}};
  sdd_src_model #(.HALF(3)) src_u (.i_clk(clk), .o_mclk(mclk), .o_bits(bits));
  sdd_top dut_u (.i_clk(clk), .i_nrst(nrst), .i_clk_en(clk_en),
    .i_master_clock_input(mclk), .i_mod_bits(bits), .i_power_mode_select(pwr),
    .i_oversampling_ratio_select(sel), .i_turbo_ratio_enable(turbo),
    .o_ch_data(data), .o_sample_valid(valid), .o_fast_settle(fast),
    .o_modulator_strobe(mstb), .o_high_resolution_mode(hr),
    .o_low_power_mode(lp), .o_very_low_power_mode(very_low_power_mode), .o_osr_log2(osr));
  // free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // n edges, then the fixed drive delay
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // six cycles low, reset values checked, then release
  task automatic do_reset();
    nrst = 1'b0;
    tick(6);
    chk({fast, valid, mstb, |data, hr, lp, very_low_power_mode, osr}, 11'h447);
    nrst = 1'b1;
    tick(5);
  endtask
  // next sample, counting modulator periods on the way
  task automatic wait_smp();
    ns = 0;
    for (int i = 0; i < 30000; i++)
    begin
      tick(1);
      if (mstb === 1'b1)
        ns++;
      if (valid === 1'b1)
        break;
    end
  endtask
  // cycles up to the next modulator strobe, 100 if none
  task automatic wait_stb();
    ns = 0;
    for (int i = 0; i < 100; i++)
    begin
      tick(1);
      ns++;
      if (mstb === 1'b1)
        break;
    end
  endtask
  // table rows, then the awkward cases
  initial
  begin
    nrst = 1'b0;
    clk_en = 1'b1;
    pwr = 2'h0;
    sel = 3'h0;
    turbo = 1'b0;
    foreach (rows[r])
    begin
      pwr = rows[r].pwr;
      sel = rows[r].sel;
      turbo = rows[r].turbo;
      do_reset();
      chk(osr, rows[r].k);
      chk({hr, lp, very_low_power_mode}, rows[r].hot);
      for (int j = 0; j < rows[r].n; j++)
      begin
        wait_smp();
        chk(ns, 1 << rows[r].k);
        chk(fast, j < 2);
        // third sample may still be settling, so its value is skipped
        if (j != 2)
        begin
          chk(data[0], 24'h800000);
          chk(data[1], 24'h000000);
          chk(data[2], 24'h400000);
        end
      end
    end
    // ratio change inside a frame waits for the frame's end
    turbo = 1'b1;
    do_reset();
    wait_smp();
    turbo = 1'b0;
    sel = 3'h0;
    tick(20);
    chk(osr, 4'h6);
    wait_smp();
    tick(2);
    chk(osr, 4'h7);
    wait_smp();
    chk(ns, 128);
    // modulator period is two master periods of six cycles
    wait_stb();
    wait_stb();
    chk(ns, 12);
    // clock enable low holds strobes back; power field followed after
    // let the strobe pulse end first, or the freeze would hold it high
    tick(1);
    clk_en = 1'b0;
    pwr = 2'h2;
    wait_stb();
    chk(ns, 100);
    chk({hr, lp, very_low_power_mode}, 3'h2);
    clk_en = 1'b1;
    tick(2);
    chk({hr, lp, very_low_power_mode}, 3'h4);
    give_verdict();
  end
  // watchdog well beyond the expected run
  initial
  begin
    repeat (90000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule
